/* File: logic/pme_pkg.sv */
// Constants, register map and carrier types of the pulse measurement engine.
package pme_pkg;
   // ==========================================================================
   // Timing
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned US_NS = 1000;
   localparam int unsigned US_CYC = US_NS / CLK_NS;
   localparam int unsigned BASE_WIN_MS = 10;
   localparam int unsigned BASE_WIN_US = BASE_WIN_MS * 1000;
   localparam logic [15:0] N_MIN = 16'h0001;
   localparam logic [15:0] N_MAX = 16'h03E8;
   localparam logic [63:0] ISO_LOW_US = 64'h0000_0000_0000_2710;
   localparam logic [63:0] ISO_HIGH_US = 64'h0000_0000_0098_9680;
   localparam logic [23:0] TDP_SPLIT_US = 24'h002710;
   // ==========================================================================
   // Scaling: millihertz, microseconds, milli-rpm
   localparam logic [39:0] FREQ_SCALE = 40'h00_3B9A_CA00;
   localparam logic [39:0] SPEED_SCALE = 40'h0D_F847_5800;
   localparam logic [31:0] VALUE_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] VALUE_MAX = 32'h7FFF_FFFF;
   // ==========================================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TIME = 8'h04;
   localparam logic [7:0] OFS_TDP = 8'h08;
   localparam logic [7:0] OFS_PPR = 8'h0C;
   localparam logic [7:0] OFS_VALUE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [15:0] TIME_RESET = 16'h0064;
   localparam logic [23:0] TDP_RESET = 24'h000FA0;
   localparam logic [15:0] PPR_RESET = 16'h0001;
   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      MODE_FREQ = 2'h0,
      MODE_PERIOD = 2'h1,
      MODE_SPEED = 2'h2,
      MODE_BAD = 2'h3
   } mode_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_DIV = 3'h2,
      ST_COMMIT = 3'h4
   } state_type;
   typedef struct packed {
      logic [15:0] ppr;
      logic [23:0] tdp;
      logic [15:0] n;
      logic rst_req;
      logic gate;
      logic iso;
      logic cont;
      mode_type mode;
   } cfg_type;
   typedef struct packed {
      logic iso_act;
      logic param_err;
      logic dn;
      logic up;
      logic ack;
      logic done;
   } status_type;
endpackage : pme_pkg

/* File: logic/pulse_measurement_engine.sv */
// Frequency, period and speed measurement engine with an APB register slave.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pulse_measurement_engine #(
   parameter int unsigned BASE_US = pme_pkg::BASE_WIN_US
) (
   input wire logic pclk, // APB clock, 100 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic pulse_in, // Pulse input pin.
   input wire logic dir_in, // Direction pin, high for up.
   input wire logic sample_in, // Bus sample instant strobe pin.
   input wire logic sync_ok_in, // Isochronous synchronism pin.
   output logic [31:0] measured_value, // Measured value; held between sample strobes in isochronous mode, else follows the engine.
   output logic measurement_done_flag // Done flag; held between sample strobes in isochronous mode, else follows the engine.
);
   // ==========================================================================
   // Input synchronisers
   logic [3:0] s1_q, s2_q, s3_q;
   logic pulse_rise, samp_rise;

   // Two flops for each pin, third stage for edge detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
      end else begin
         s1_q <= {sync_ok_in, sample_in, dir_in, pulse_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign pulse_rise = s2_q[0] & ~s3_q[0];
   assign samp_rise = s2_q[2] & ~s3_q[2];

   // ==========================================================================
   // Register file
   pme_pkg::cfg_type cfg_q, cfg_d, act_q, act_d;
   pme_pkg::status_type st_fb_q, st_fb_d, st_now;
   logic [31:0] prdata_q, prdata_d, value_q, fb_value_q, fb_value_d;
   logic iso_act_q, iso_act_d, param_err, mapped;
   logic [63:0] win_us;
   logic wr;

   assign wr = psel & penable & pwrite;
   assign mapped = (paddr == pme_pkg::OFS_CTRL) || (paddr == pme_pkg::OFS_TIME) ||
                   (paddr == pme_pkg::OFS_TDP) || (paddr == pme_pkg::OFS_PPR) ||
                   (paddr == pme_pkg::OFS_VALUE) || (paddr == pme_pkg::OFS_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_q;
   assign win_us = 64'(cfg_q.n) * 64'(cfg_q.tdp);
   assign measured_value = fb_value_q;
   assign measurement_done_flag = st_fb_q.done;

   // Parameter check: window count range, mode, pulses per revolution, and the window against the bus cycle period in isochronous mode.
   always_comb begin
      param_err = (cfg_q.n < pme_pkg::N_MIN) || (cfg_q.n > pme_pkg::N_MAX) ||
                  (cfg_q.mode == pme_pkg::MODE_BAD) ||
                  (cfg_q.mode == pme_pkg::MODE_SPEED && cfg_q.ppr == 16'h0000);
      if (cfg_q.iso) begin
         if (cfg_q.tdp < pme_pkg::TDP_SPLIT_US) begin
            param_err = param_err | (win_us <= pme_pkg::ISO_LOW_US);
         end else begin
            param_err = param_err | (win_us > pme_pkg::ISO_HIGH_US);
         end
      end
   end

   // Writes, read data capture, and the sample-instant snapshots.
   always_comb begin
      cfg_d = cfg_q;
      if (wr) begin
         unique case (paddr)
            pme_pkg::OFS_CTRL: begin
               cfg_d.mode = pme_pkg::mode_type'(pwdata[1:0]);
               cfg_d.cont = pwdata[2];
               cfg_d.iso = pwdata[3];
               cfg_d.gate = pwdata[4];
               cfg_d.rst_req = pwdata[5];
            end
            pme_pkg::OFS_TIME: cfg_d.n = pwdata[15:0];
            pme_pkg::OFS_TDP: cfg_d.tdp = pwdata[23:0];
            pme_pkg::OFS_PPR: cfg_d.ppr = pwdata[15:0];
            default: cfg_d = cfg_q;
         endcase
      end
      prdata_d = prdata_q;
      if (psel && !penable) begin
         unique case (paddr)
            pme_pkg::OFS_CTRL: prdata_d = {26'h0, cfg_q.rst_req, cfg_q.gate, cfg_q.iso, cfg_q.cont, cfg_q.mode};
            pme_pkg::OFS_TIME: prdata_d = {16'h0, cfg_q.n};
            pme_pkg::OFS_TDP: prdata_d = {8'h0, cfg_q.tdp};
            pme_pkg::OFS_PPR: prdata_d = {16'h0, cfg_q.ppr};
            pme_pkg::OFS_VALUE: prdata_d = fb_value_q;
            pme_pkg::OFS_STATUS: prdata_d = {26'h0, st_fb_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      iso_act_d = cfg_q.iso & ~param_err;
      act_d = cfg_q;
      fb_value_d = value_q;
      st_fb_d = st_now;
      if ((iso_act_q || iso_act_d) && !samp_rise) begin
         act_d = act_q;
         fb_value_d = fb_value_q;
         st_fb_d = st_fb_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= '{ppr: pme_pkg::PPR_RESET, tdp: pme_pkg::TDP_RESET, n: pme_pkg::TIME_RESET,
                    mode: pme_pkg::MODE_FREQ, default: 1'b0};
         act_q <= '{ppr: pme_pkg::PPR_RESET, tdp: pme_pkg::TDP_RESET, n: pme_pkg::TIME_RESET,
                    mode: pme_pkg::MODE_FREQ, default: 1'b0};
         prdata_q <= 32'h0000_0000;
         iso_act_q <= 1'b0;
         fb_value_q <= pme_pkg::VALUE_INIT;
         st_fb_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         act_q <= act_d;
         prdata_q <= prdata_d;
         iso_act_q <= iso_act_d;
         fb_value_q <= fb_value_d;
         st_fb_q <= st_fb_d;
      end
   end

   // ==========================================================================
   // Measurement engine
   pme_pkg::state_type state_q, state_d;
   logic [6:0] usdiv_q, usdiv_d, cnt_q, cnt_d;
   logic [31:0] us_q, us_d, base_q, base_d, first_q, first_d, last_q, last_d;
   logic [31:0] prev_q, prev_d, value_d, res, dt;
   logic [15:0] wcnt_q, wcnt_d, wn_q, wn_d;
   logic [23:0] edges_q, edges_d, pulses;
   logic [63:0] num_q, num_d;
   logic [47:0] den_q, den_d;
   logic [48:0] rem_q, rem_d, rem_sh;
   logic ext_q, ext_d, ref_q, ref_d, est_q, est_d, zero_q, zero_d;
   logic upa_q, upa_d, dna_q, dna_d, up_q, up_d, dn_q, dn_d;
   logic done_q, done_d, ack_q, ack_d, tick, win_end, us_tick, last_slot, take;

   assign st_now = '{iso_act: iso_act_q, param_err: param_err, dn: dn_q, up: up_q,
                     ack: ack_q, done: done_q};
   assign us_tick = (usdiv_q == 7'(pme_pkg::US_CYC - 1));
   assign tick = iso_act_q ? samp_rise : (us_tick && base_q == BASE_US - 1);
   assign last_slot = (wcnt_q + 16'h0001 >= wn_q);
   assign win_end = tick & act_q.gate & (ext_q | (last_slot & ~(iso_act_q & ~s2_q[3])));
   assign rem_sh = {rem_q[47:0], num_q[63]};
   assign res = (|num_q[63:31]) ? pme_pkg::VALUE_MAX : num_q[31:0];

   always_comb begin
      usdiv_d = us_tick ? 7'h00 : usdiv_q + 7'h01;
      us_d = us_tick ? us_q + 32'h1 : us_q;
      base_d = base_q;
      if (us_tick) begin
         base_d = (base_q == BASE_US - 1) ? 32'h0 : base_q + 32'h1;
      end
      state_d = state_q;
      wcnt_d = wcnt_q;
      wn_d = wn_q;
      ext_d = ext_q;
      edges_d = edges_q;
      first_d = first_q;
      last_d = last_q;
      prev_d = prev_q;
      ref_d = ref_q;
      upa_d = upa_q;
      dna_d = dna_q;
      est_d = est_q;
      zero_d = zero_q;
      num_d = num_q;
      den_d = den_q;
      rem_d = rem_q;
      cnt_d = cnt_q;
      value_d = value_q;
      up_d = up_q;
      dn_d = dn_q;
      pulses = 24'h0;
      dt = 32'h0;
      take = 1'b1;
      // Count and timestamp edges while the gate is open.
      if (!act_q.gate) begin
         wcnt_d = 16'h0;
         wn_d = act_q.n;
         ext_d = 1'b0;
         edges_d = 24'h0;
         ref_d = 1'b0;
      end else if (pulse_rise) begin
         edges_d = edges_q + 24'h1;
         last_d = us_q;
         if (edges_q == 24'h0 || win_end) begin
            first_d = us_q;
         end
         upa_d = upa_q | s2_q[1];
         dna_d = dna_q | ~s2_q[1];
      end
      if (tick && act_q.gate && !win_end) begin
         wcnt_d = wcnt_q + 16'h1;
         ext_d = last_slot;
      end
      // Window end: form the operands and start the divider.
      if (win_end) begin
         wcnt_d = 16'h0;
         wn_d = act_q.n;
         ext_d = 1'b0;
         edges_d = {23'h0, pulse_rise}; // A pulse on the closing edge opens the next window.
         upa_d = pulse_rise & s2_q[1];
         dna_d = pulse_rise & ~s2_q[1];
         up_d = upa_q;
         dn_d = dna_q;
         est_d = 1'b0;
         if (act_q.cont && ref_q && edges_q != 24'h0) begin
            pulses = edges_q;
            dt = last_q - prev_q;
         end else if (act_q.cont && ref_q) begin
            pulses = 24'h1;
            dt = us_q - prev_q;
            est_d = 1'b1;
         end else if (edges_q > 24'h1) begin
            pulses = edges_q - 24'h1;
            dt = last_q - first_q;
         end
         if (edges_q != 24'h0) begin
            prev_d = last_q;
            ref_d = 1'b1;
         end
         zero_d = (pulses == 24'h0) || (dt == 32'h0);
         unique case (act_q.mode)
            pme_pkg::MODE_PERIOD: begin
               num_d = {32'h0, dt};
               den_d = {24'h0, pulses};
            end
            pme_pkg::MODE_SPEED: begin
               num_d = 64'(pulses) * 64'(pme_pkg::SPEED_SCALE);
               den_d = 48'(dt) * 48'(act_q.ppr);
            end
            default: begin
               num_d = 64'(pulses) * 64'(pme_pkg::FREQ_SCALE);
               den_d = {16'h0, dt};
            end
         endcase
         rem_d = 49'h0;
         cnt_d = 7'h0;
         state_d = pme_pkg::ST_DIV;
      end
      unique case (state_q)
         pme_pkg::ST_IDLE: begin
         end
         // Restoring division, one quotient bit per clock.
         pme_pkg::ST_DIV: begin
            if (rem_sh >= {1'b0, den_q}) begin
               rem_d = rem_sh - {1'b0, den_q};
               num_d = {num_q[62:0], 1'b1};
            end else begin
               rem_d = rem_sh;
               num_d = {num_q[62:0], 1'b0};
            end
            cnt_d = cnt_q + 7'h1;
            if (cnt_q == 7'h3F) begin
               state_d = pme_pkg::ST_COMMIT;
            end
         end
         // Publish the result; estimates only replace in one direction.
         pme_pkg::ST_COMMIT: begin
            if (est_q && act_q.mode == pme_pkg::MODE_PERIOD) begin
               take = $signed(res) > $signed(value_q);
            end else if (est_q) begin
               take = res < value_q;
            end
            if (zero_q) begin
               value_d = 32'h0000_0000;
            end else if (take) begin
               value_d = res;
            end
            state_d = pme_pkg::ST_IDLE;
         end
      endcase
      // Done flag: set at commit wins over the request/ack clear.
      ack_d = act_q.rst_req;
      done_d = done_q & ~(act_q.rst_req & ~ack_q);
      if (state_q == pme_pkg::ST_COMMIT) begin
         done_d = 1'b1;
      end
   end

   // Registers of the engine; value stays at minus one until the first window's result is committed after the divider.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= pme_pkg::ST_IDLE;
         usdiv_q <= 7'h00;
         us_q <= 32'h0;
         base_q <= 32'h0;
         wcnt_q <= 16'h0;
         wn_q <= pme_pkg::TIME_RESET;
         ext_q <= 1'b0;
         edges_q <= 24'h0;
         first_q <= 32'h0;
         last_q <= 32'h0;
         prev_q <= 32'h0;
         ref_q <= 1'b0;
         upa_q <= 1'b0;
         dna_q <= 1'b0;
         est_q <= 1'b0;
         zero_q <= 1'b0;
         num_q <= 64'h0;
         den_q <= 48'h0;
         rem_q <= 49'h0;
         cnt_q <= 7'h0;
         value_q <= pme_pkg::VALUE_INIT;
         up_q <= 1'b0;
         dn_q <= 1'b0;
         done_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         usdiv_q <= usdiv_d;
         us_q <= us_d;
         base_q <= base_d;
         wcnt_q <= wcnt_d;
         wn_q <= wn_d;
         ext_q <= ext_d;
         edges_q <= edges_d;
         first_q <= first_d;
         last_q <= last_d;
         prev_q <= prev_d;
         ref_q <= ref_d;
         upa_q <= upa_d;
         dna_q <= dna_d;
         est_q <= est_d;
         zero_q <= zero_d;
         num_q <= num_d;
         den_q <= den_d;
         rem_q <= rem_d;
         cnt_q <= cnt_d;
         value_q <= value_d;
         up_q <= up_d;
         dn_q <= dn_d;
         done_q <= done_d;
         ack_q <= ack_d;
      end
   end
endmodule : pulse_measurement_engine

`default_nettype wire

/* File: test/pme_properties.sv */
// Port-level checker of the pulse measurement engine.
`timescale 1ns/1ps
`default_nettype none
module pme_properties #(
   parameter int unsigned BASE_US = 10
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB address.
   input wire logic [31:0] pwdata, // APB write data.
   input wire logic [31:0] prdata, // APB read data.
   input wire logic pready, // APB ready.
   input wire logic pslverr, // APB error.
   input wire logic pulse_in, // Pulse pin.
   input wire logic dir_in, // Direction pin.
   input wire logic sample_in, // Sample strobe.
   input wire logic sync_ok_in, // Synchronism pin.
   input wire logic [31:0] measured_value, // Feedback value.
   input wire logic measurement_done_flag // Done flag.
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================================
   // Helper state
   logic req_q;
   logic req_d;
   // Copy of the last status reset request written by software.
   always_comb begin
      req_d = req_q;
      if (psel && penable && pwrite && paddr == pme_pkg::OFS_CTRL) begin
         req_d = pwdata[5];
      end
   end
   // Register of the request copy.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
      end else begin
         req_q <= req_d;
      end
   end
   // ==========================================================================
   // Assertions
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped address");
   a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved without setup");
   a_done_value: assert property ($rose(measurement_done_flag) |-> measured_value != pme_pkg::VALUE_INIT)
      else $error("done set with initial value");
   a_value_done: assert property ($changed(measured_value) |-> ##[0:2] measurement_done_flag)
      else $error("value changed without done");
   a_value_range: assert property (measured_value != pme_pkg::VALUE_INIT |-> measured_value <= pme_pkg::VALUE_MAX)
      else $error("value out of range");
   a_done_clear: assert property ($fell(measurement_done_flag) |-> req_q)
      else $error("done cleared without request");
endmodule : pme_properties
bind pulse_measurement_engine pme_properties #(.BASE_US(BASE_US)) i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in), .dir_in(dir_in), .sample_in(sample_in),
   .sync_ok_in(sync_ok_in), .measured_value(measured_value), .measurement_done_flag(measurement_done_flag));
`default_nettype wire

/* File: test/pme_pulse_source.sv */
// Field side model: pulse train, direction level and bus sample strobes.
`timescale 1ns/1ps
`default_nettype none
module pme_pulse_source (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic [15:0] half_cyc, // Half period in clocks, 0 stops.
   input wire logic dir_up, // Direction wanted.
   input wire logic sync_ok, // Synchronism wanted.
   output logic pulse_in, // Pulse train.
   output logic dir_in, // Direction level.
   output logic sample_in, // Sample instant strobe.
   output logic sync_ok_in // Synchronism good.
);
   logic [15:0] cnt_q;
   logic [8:0] smp_q;
   // Pulse train; it rests low while stopped so no stray edge is seen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
         pulse_in <= 1'b0;
      end else if (half_cyc == 16'h0000) begin
         cnt_q <= 16'h0000;
         pulse_in <= 1'b0;
      end else if (cnt_q + 16'h0001 >= half_cyc) begin
         cnt_q <= 16'h0000;
         pulse_in <= !pulse_in;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
   // Bus cycle of 400 clocks, one strobe per cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_q <= 9'h000;
      end else begin
         smp_q <= (smp_q == 9'h18F) ? 9'h000 : smp_q + 9'h001;
      end
   end
   assign sample_in = (smp_q == 9'h000);
   assign dir_in = dir_up;
   assign sync_ok_in = sync_ok;
endmodule : pme_pulse_source
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking testbench of the pulse measurement engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic pulse_in, dir_in, sample_in, sync_ok_in, measurement_done_flag, dir_up, sync_ok;
   logic [7:0] paddr;
   logic [15:0] half_cyc;
   logic [31:0] pwdata, prdata, measured_value, rd;
   int mismatches, n_checks, cycles;
   // Clock of 100 MHz.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = !pclk;
   end
   pulse_measurement_engine #(.BASE_US(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse_in(pulse_in), .dir_in(dir_in), .sample_in(sample_in),
      .sync_ok_in(sync_ok_in), .measured_value(measured_value), .measurement_done_flag(measurement_done_flag));
   pme_pulse_source i_src (.pclk(pclk), .presetn(presetn), .half_cyc(half_cyc), .dir_up(dir_up), .sync_ok(sync_ok),
      .pulse_in(pulse_in), .dir_in(dir_in), .sample_in(sample_in), .sync_ok_in(sync_ok_in));
   // ==========================================================================
   // Bus and compare tasks
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic check_range(input string what, input logic [31:0] lo, input logic [31:0] hi);
      n_checks++;
      if (!(rd >= lo && rd <= hi) || $isunknown(rd)) begin
         mismatches++;
         $display("ERROR %s expected %h..%h seen %h", what, lo, hi, rd);
      end
   endtask : check_range
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset
   task automatic wait_done();
      rd = 32'h0000_0000;
      while (rd[0] !== 1'b1) apb(1'b0, pme_pkg::OFS_STATUS, 32'h0000_0000);
   endtask : wait_done
   // Full request and acknowledge handshake on the done flag.
   task automatic clear_done(input logic [31:0] ctrl);
      apb(1'b1, pme_pkg::OFS_CTRL, ctrl | 32'h0000_0020);
      do apb(1'b0, pme_pkg::OFS_STATUS, 32'h0000_0000); while (rd[1] !== 1'b1);
      check("done after request", 32'h0000_0000, {31'h0, rd[0]});
      apb(1'b1, pme_pkg::OFS_CTRL, ctrl);
      do apb(1'b0, pme_pkg::OFS_STATUS, 32'h0000_0000); while (rd[1] !== 1'b0);
   endtask : clear_done
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      logic [31:0] exp [6];
      exp = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0FA0, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0000};
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0000_0000);
         check("reset value", exp[i], rd);
      end
      apb(1'b1, pme_pkg::OFS_VALUE, 32'h0000_1234);
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check("read-only value", 32'hFFFF_FFFF, rd);
      apb(1'b0, 8'h18, 32'h0000_0000);
      check("unmapped error", 32'h0000_0001, {31'h0, err});
   endtask : t_reset
   task automatic t_integ();
      half_cyc <= 16'h0032;
      apb(1'b1, pme_pkg::OFS_TIME, 32'h0000_0002);
      apb(1'b1, pme_pkg::OFS_CTRL, 32'h0000_0010);
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check("value before window", 32'hFFFF_FFFF, rd);
      wait_done();
      check("done pin", 32'h0000_0001, {31'h0, measurement_done_flag});
      check("direction one way", 32'h0000_0001, {30'h0, rd[3:2]});
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check_range("frequency mHz", 32'h35A4_E900, 32'h4190_AB00);
      clear_done(32'h0000_0010);
      repeat (500) @(posedge pclk);
      dir_up <= 1'b0;
      wait_done();
      check("direction reversed", 32'h0000_0003, {30'h0, rd[3:2]});
      half_cyc <= 16'h0000;
      clear_done(32'h0000_0010);
      wait_done();
      clear_done(32'h0000_0010);
      wait_done();
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check("no edges value", 32'h0000_0000, rd);
      check("value pin", 32'h0000_0000, measured_value);
   endtask : t_integ
   task automatic t_cont();
      half_cyc <= 16'h00FA;
      apb(1'b1, pme_pkg::OFS_TIME, 32'h0000_0002);
      apb(1'b1, pme_pkg::OFS_CTRL, 32'h0000_0015);
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check("value before interval", 32'hFFFF_FFFF, rd);
      wait_done();
      clear_done(32'h0000_0015);
      wait_done();
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check_range("period us", 32'h0000_0004, 32'h0000_0006);
      half_cyc <= 16'h0000;
      clear_done(32'h0000_0015);
      wait_done();
      clear_done(32'h0000_0015);
      wait_done();
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check_range("estimated period", 32'h0000_0010, 32'h7FFF_FFFF);
   endtask : t_cont
   // Fields: control, window count, bus cycle period, expected error.
   task automatic t_param();
      logic [63:0] tbl [9];
      tbl = '{64'h10_03E8_000FA0_00, 64'h10_0000_000FA0_01, 64'h10_03E9_000FA0_01,
         64'h13_0001_000FA0_01, 64'h15_0001_000FA0_00, 64'h16_0001_000FA0_00,
         64'h18_0002_000FA0_01, 64'h18_0003_000FA0_00, 64'h18_01F5_004E20_01};
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, pme_pkg::OFS_TDP, {8'h00, tbl[i][31:8]});
         apb(1'b1, pme_pkg::OFS_TIME, {16'h0000, tbl[i][47:32]});
         apb(1'b1, pme_pkg::OFS_CTRL, {24'h00_0000, tbl[i][55:48]});
         repeat (900) @(posedge pclk);
         apb(1'b0, pme_pkg::OFS_STATUS, 32'h0000_0000);
         check("error and iso", {30'h0, tbl[i][51] & !tbl[i][0], tbl[i][0]}, {30'h0, rd[5:4]});
      end
   endtask : t_param
   // Isochronous windows of three bus cycles, then with synchronism lost.
   task automatic t_iso();
      half_cyc <= 16'h0032;
      apb(1'b1, pme_pkg::OFS_TIME, 32'h0000_0003);
      apb(1'b1, pme_pkg::OFS_CTRL, 32'h0000_0018);
      wait_done();
      check("iso active", 32'h0000_0001, {31'h0, rd[5]});
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check_range("iso frequency", 32'h35A4_E900, 32'h4190_AB00);
      sync_ok <= 1'b0;
      clear_done(32'h0000_0018);
      wait_done();
      apb(1'b0, pme_pkg::OFS_VALUE, 32'h0000_0000);
      check_range("extended window", 32'h35A4_E900, 32'h4190_AB00);
      sync_ok <= 1'b1;
   endtask : t_iso
   task automatic results();
      if (mismatches == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   // Main sequence.
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, half_cyc} = '0;
      dir_up = 1'b1;
      sync_ok = 1'b1;
      do_reset();
      t_reset();
      t_integ();
      do_reset();
      t_cont();
      do_reset();
      t_param();
      do_reset();
      t_iso();
      results();
   end
   // Cuts a hang short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 80000) begin
         mismatches++;
         results();
      end
   end
endmodule : testbench
`default_nettype wire
